// >>> hdl/rap_defs.svh
// Constants for the register access packet server
`ifndef RAP_DEFS_SVH
`define RAP_DEFS_SVH
// ****************************************
// Ports and format
// ****************************************
`define RAP_PORT_MAIN 16'h052c
`define RAP_PORT_LEGACY 16'hc350
`define RAP_VERSION 8'h02
`define RAP_RSVD 8'h00
`define RAP_HDR_BYTES 7
// ****************************************
// Length and count limits
// ****************************************
`define RAP_LEN_MIN 16'h0005
`define RAP_LEN_MAX_UDP 16'h040a
`define RAP_LEN_MAX_TCP 16'h100a
`define RAP_CNT_MAX_UDP 16'h0200
`define RAP_CNT_MAX_TCP 16'h0800
// ****************************************
// Operation codes and queue depth
// ****************************************
`define RAP_OP_MAX 8'h1f
`define RAP_OP_OK 8'h80
`define RAP_OP_FAIL 8'h40
`define RAP_OP_RD_LE 8'h10
`define RAP_OP_WR_LE 8'h11
`define RAP_OP_RD_BE 8'h12
`define RAP_OP_WR_BE 8'h13
`define RAP_PEND_DEPTH 4
`endif

// >>> hdl/rap_pkg.sv
// Types for the register access packet server
package rap_pkg;
  typedef enum logic [4:0] {
    RAP_HDR = 5'b00001,
    RAP_ARG = 5'b00010,
    RAP_WDATA = 5'b00100,
    RAP_DRAIN = 5'b01000,
    RAP_DONE = 5'b10000
  } rap_rx_t;
  typedef enum logic [3:0] {
    RAP_IDLE = 4'b0001,
    RAP_THDR = 4'b0010,
    RAP_TDATA = 4'b0100,
    RAP_TEND = 4'b1000
  } rap_tx_t;
endpackage

// >>> hdl/rap_swap.sv
// Byte order helper for 16-bit words
`timescale 1ns/100ps
module rap_swap (
  // Word in and order select
  input wire logic [15:0] din,
  input wire logic big,
  // Wire order word out, low byte on wire first
  output logic [15:0] dout
);
  assign dout = big ? {din[7:0], din[15:8]} : din;
endmodule // rap_swap

// >>> hdl/rap_pend.sv
// Small in-order queue of pending response headers
`timescale 1ns/100ps
module rap_pend #(
  parameter int W = 56,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Push side
  input wire logic push,
  input wire logic [W-1:0] wdata,
  output logic full,
  // Pop side
  input wire logic pop,
  output logic [W-1:0] rdata,
  output logic empty
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  assign full = (cnt_r == (AW+1)'(DEPTH));
  assign empty = (cnt_r == '0);
  assign rdata = mem_r[rp_r];
  always_ff @(posedge clk) begin
    if (push && !full) begin
      mem_r[wp_r] <= wdata;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push && !full) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop && !empty) begin
        rp_r <= rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push && !full) - (AW+1)'(pop && !empty);
    end
  end
endmodule // rap_pend

// >>> hdl/rap_server.sv
// Register access packet server: parses requests, returns responses
// Functional notes
// - Accept requests on main port both transports
// - Also accept requests on legacy port
// - Binary values, little endian header words
// - Register data order chosen by operation code
// - No application checksum sent or expected
// - No node address fields in packets
// - Exactly one response per request of two or more bytes
// - Responses leave in request arrival order
// - Response reuses request header layout
// - Length counts bytes after length field
// - Length range 5-1034 UDP, 5-4106 TCP
// - Version byte is 02 both ways
// - Sequence tag echoed unchanged
// - Request codes are one byte, 00-1F
// - Success code is request plus 80
// - Failure code is request plus 40
// - 65536 registers of 16 bits addressable
// - Codes 10-13 read/write LE and BE
// - Register count 1-2048 TCP, 1-512 UDP
`timescale 1ns/100ps
`include "rap_defs.svh"
module rap_server import rap_pkg::*; #(
  parameter int DEPTH = `RAP_PEND_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Request byte stream from transport, one packet per first..last
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_first,
  input wire logic rx_last,
  input wire logic rx_is_tcp,
  input wire logic [15:0] rx_dst_port,
  output logic rx_ready,
  // Response byte stream to transport
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  input wire logic tx_ready,
  // Register space access
  output logic reg_we,
  output logic reg_re,
  output logic [15:0] reg_addr,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  // Status
  output logic drop_pulse
);
  // ****************************************
  // Receive side
  // ****************************************
  rap_rx_t rx_st_r;
  logic [3:0] idx_r;
  logic [15:0] len_r;
  logic [15:0] bcnt_r;
  logic [7:0] ver_r;
  logic [15:0] tag_r;
  logic [7:0] op_r;
  logic [15:0] addr_r;
  logic [15:0] cnt_r;
  logic [15:0] wcnt_r;
  logic [7:0] lo_r;
  logic tcp_r;
  logic port_ok;
  logic rx_take;
  logic hdr_bad;
  logic req_ok;
  logic is_rw;
  logic is_wr;
  logic big;
  logic [15:0] len_max;
  logic [15:0] cnt_max;
  logic [15:0] want_len;
  logic [15:0] wire_word;
  logic [15:0] wr_word;
  logic pend_full;
  logic pend_empty;
  logic pend_pop;
  logic [50:0] pend_wdata;
  logic [50:0] pend_rdata;
  logic push_r;
  logic drop_r;
  logic re_r;
  logic we_r;
  logic [15:0] raddr_r;
  logic [15:0] wdat_r;

  assign port_ok = (rx_dst_port == `RAP_PORT_MAIN) ||
                   (rx_dst_port == `RAP_PORT_LEGACY);
  // Stall the stream while the pending queue cannot take a header
  // Write data waits for earlier replies, so older reads see old data
  assign rx_ready = (rx_st_r != RAP_DONE) && !pend_full &&
                    !(rx_st_r == RAP_WDATA && !pend_empty);
  assign rx_take = rx_valid && rx_ready;
  assign len_max = tcp_r ? `RAP_LEN_MAX_TCP : `RAP_LEN_MAX_UDP;
  assign cnt_max = tcp_r ? `RAP_CNT_MAX_TCP : `RAP_CNT_MAX_UDP;
  assign is_rw = (op_r >= `RAP_OP_RD_LE) && (op_r <= `RAP_OP_WR_BE);
  assign is_wr = (op_r == `RAP_OP_WR_LE) || (op_r == `RAP_OP_WR_BE);
  assign big = (op_r == `RAP_OP_RD_BE) || (op_r == `RAP_OP_WR_BE);
  // expected length: header after length plus address and count, plus two bytes per word on writes
  assign want_len = is_wr ? 16'(16'h000a + {cnt_r[14:0], 1'b0}) : 16'h000a;
  assign hdr_bad = (ver_r != `RAP_VERSION) || (len_r < `RAP_LEN_MIN) ||
                   (len_r > len_max) || (op_r > `RAP_OP_MAX) || !is_rw;
  assign req_ok = !hdr_bad && (cnt_r != 16'h0000) && (cnt_r <= cnt_max) &&
                  (len_r == want_len);

  rap_swap u_wr_swap (
    .din({rx_data, lo_r}),
    .big(big),
    .dout(wr_word)
  );

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_st_r <= RAP_HDR;
      idx_r <= 4'h0;
      len_r <= 16'h0000;
      bcnt_r <= 16'h0000;
      ver_r <= 8'h00;
      tag_r <= 16'h0000;
      op_r <= 8'h00;
      addr_r <= 16'h0000;
      cnt_r <= 16'h0000;
      wcnt_r <= 16'h0000;
      lo_r <= 8'h00;
      tcp_r <= 1'b0;
      push_r <= 1'b0;
      drop_r <= 1'b0;
      we_r <= 1'b0;
      wdat_r <= 16'h0000;
    end else begin
      push_r <= 1'b0;
      drop_r <= 1'b0;
      we_r <= 1'b0;
      case (rx_st_r)
        RAP_HDR: begin
          if (rx_take) begin
            if (rx_first) begin
              idx_r <= 4'h1;
              len_r <= {8'h00, rx_data};
              tcp_r <= rx_is_tcp;
              op_r <= 8'hff;
              cnt_r <= 16'h0000;
              if (!port_ok) begin
                drop_r <= 1'b1;
                rx_st_r <= rx_last ? RAP_HDR : RAP_DRAIN;
              end
            end else begin
              idx_r <= idx_r + 4'h1;
              case (idx_r)
                4'h1: len_r[15:8] <= rx_data;
                4'h3: ver_r <= rx_data;
                4'h4: tag_r[7:0] <= rx_data;
                4'h5: tag_r[15:8] <= rx_data;
                4'h6: op_r <= rx_data;
                default: ;
              endcase
              if (idx_r == 4'h6) begin
                rx_st_r <= rx_last ? RAP_DONE : RAP_ARG;
              end else if (rx_last) begin
                // Runt packet of two to six bytes still answered with failure
                rx_st_r <= RAP_DONE;
              end
            end
          end
        end
        RAP_ARG: begin
          if (rx_take) begin
            idx_r <= idx_r + 4'h1;
            // address and count follow the data order
            case (idx_r)
              4'h8: lo_r <= rx_data;
              4'h9: addr_r <= big ? {lo_r, rx_data} : {rx_data, lo_r};
              4'ha: lo_r <= rx_data;
              4'hb: cnt_r <= big ? {lo_r, rx_data} : {rx_data, lo_r};
              default: ;
            endcase
            if (rx_last) begin
              rx_st_r <= RAP_DONE;
            end else if (idx_r == 4'hb && is_wr) begin
              bcnt_r <= 16'h0000;
              wcnt_r <= 16'h0000;
              rx_st_r <= RAP_WDATA;
            end else if (idx_r == 4'hb) begin
              rx_st_r <= RAP_DRAIN;
            end
          end
        end
        RAP_WDATA: begin
          if (rx_take) begin
            bcnt_r <= bcnt_r + 16'h0001;
            if (bcnt_r[0]) begin
              // writes only when the whole request is sound
              if (!hdr_bad && cnt_r != 16'h0000 && cnt_r <= cnt_max &&
                  len_r == want_len && wcnt_r < cnt_r) begin
                we_r <= 1'b1;
                wdat_r <= wr_word;
              end
              wcnt_r <= wcnt_r + 16'h0001;
            end else begin
              lo_r <= rx_data;
            end
            if (rx_last) begin
              rx_st_r <= RAP_DONE;
            end
          end
        end
        RAP_DRAIN: begin
          if (rx_take && rx_last) begin
            rx_st_r <= drop_r ? RAP_HDR : RAP_DONE;
          end
        end
        RAP_DONE: begin
          // one queue entry per received request
          push_r <= 1'b1;
          rx_st_r <= RAP_HDR;
        end
        default: rx_st_r <= RAP_HDR;
      endcase
    end
  end

  // Stray-port drain needs to remember a dropped packet across bytes
  logic drop_hold_r;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      drop_hold_r <= 1'b0;
    end else if (drop_r) begin
      drop_hold_r <= 1'b1;
    end else if (rx_st_r == RAP_HDR) begin
      drop_hold_r <= 1'b0;
    end
  end
  assign drop_pulse = drop_r;

  // ok flag, big flag, tag, code, address, count
  assign pend_wdata = {req_ok, big, tag_r, op_r[4:0], addr_r,
                       (req_ok && !is_wr) ? cnt_r[11:0] : 12'h000};

  rap_pend #(
    .W(51),
    .DEPTH(DEPTH)
  ) u_pend (
    .clk(clk),
    .sys_rst(sys_rst),
    .push(push_r && (rx_st_r == RAP_HDR) && !drop_hold_r),
    .wdata(pend_wdata),
    .full(pend_full),
    .pop(pend_pop),
    .rdata(pend_rdata),
    .empty(pend_empty)
  );

  // ****************************************
  // Transmit side
  // ****************************************
  rap_tx_t tx_st_r;
  logic [3:0] tidx_r;
  logic [11:0] rleft_r;
  logic [15:0] rdw_r;
  logic hi_r;
  logic tv_r;
  logic [7:0] td_r;
  logic tl_r;
  logic [15:0] rlen;
  logic [7:0] rop;
  logic [15:0] rd_word;
  logic p_ok;
  logic p_big;
  logic [15:0] p_tag;
  logic [4:0] p_op;
  logic [15:0] p_addr;
  logic [11:0] p_cnt;
  logic tx_adv;

  assign {p_ok, p_big, p_tag, p_op, p_addr, p_cnt} = pend_rdata;
  assign rop = p_ok ? (`RAP_OP_OK | {3'b000, p_op}) :
                      (`RAP_OP_FAIL | {3'b000, p_op});
  // response length: five bytes, or six with pad plus read data
  assign rlen = (p_cnt == 12'h000) ? 16'h0005 :
                16'(16'h0006 + {3'b000, p_cnt, 1'b0});
  assign tx_adv = !tv_r || tx_ready;
  assign pend_pop = (tx_st_r == RAP_TEND) && tx_adv;

  rap_swap u_rd_swap (
    .din(reg_rdata),
    .big(p_big),
    .dout(rd_word)
  );

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_st_r <= RAP_IDLE;
      tidx_r <= 4'h0;
      rleft_r <= 12'h000;
      rdw_r <= 16'h0000;
      hi_r <= 1'b0;
      tv_r <= 1'b0;
      td_r <= 8'h00;
      tl_r <= 1'b0;
      re_r <= 1'b0;
      raddr_r <= 16'h0000;
    end else begin
      re_r <= 1'b0;
      if (tv_r && tx_ready) begin
        tv_r <= 1'b0;
        tl_r <= 1'b0;
      end
      case (tx_st_r)
        RAP_IDLE: begin
          if (!pend_empty) begin
            tidx_r <= 4'h0;
            rleft_r <= p_cnt;
            raddr_r <= p_addr;
            tx_st_r <= RAP_THDR;
          end
        end
        RAP_THDR: begin
          if (tx_adv) begin
            tv_r <= 1'b1;
            tidx_r <= tidx_r + 4'h1;
            case (tidx_r)
              4'h0: td_r <= rlen[7:0];
              4'h1: td_r <= rlen[15:8];
              4'h2: td_r <= `RAP_RSVD;
              4'h3: td_r <= `RAP_VERSION;
              4'h4: td_r <= p_tag[7:0];
              4'h5: td_r <= p_tag[15:8];
              4'h6: td_r <= rop;
              default: td_r <= `RAP_RSVD;
            endcase
            if (tidx_r == 4'h6 && rleft_r == 12'h000) begin
              tl_r <= 1'b1;
              tx_st_r <= RAP_TEND;
            end else if (tidx_r == 4'h7) begin
              // pad byte keeps read data word aligned
              hi_r <= 1'b0;
              re_r <= 1'b1;
              tx_st_r <= RAP_TDATA;
            end
          end
        end
        RAP_TDATA: begin
          // Read data is taken at the end of the strobe cycle; one byte per slot
          if (re_r) begin
            rdw_r <= rd_word;
          end else if (tx_adv) begin
            tv_r <= 1'b1;
            hi_r <= !hi_r;
            td_r <= hi_r ? rdw_r[15:8] : rdw_r[7:0];
            if (hi_r) begin
              rleft_r <= rleft_r - 12'h001;
              raddr_r <= raddr_r + 16'h0001;
              if (rleft_r == 12'h001) begin
                tl_r <= 1'b1;
                tx_st_r <= RAP_TEND;
              end else begin
                re_r <= 1'b1;
              end
            end
          end
        end
        RAP_TEND: begin
          if (tx_adv) begin
            tx_st_r <= RAP_IDLE;
          end
        end
        default: tx_st_r <= RAP_IDLE;
      endcase
    end
  end

  // no checksum or node fields on the wire
  assign tx_valid = tv_r;
  assign tx_data = td_r;
  assign tx_last = tl_r;
  assign reg_re = re_r;
  assign reg_we = we_r;
  assign reg_wdata = wdat_r;

  // write address walks the 16-bit space
  logic [15:0] waddr_r;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      waddr_r <= 16'h0000;
    end else if (rx_st_r == RAP_ARG && idx_r == 4'h9 && rx_take) begin
      waddr_r <= big ? {lo_r, rx_data} : {rx_data, lo_r};
    end else if (we_r) begin
      waddr_r <= waddr_r + 16'h0001;
    end
  end
  assign reg_addr = we_r ? waddr_r : raddr_r;
endmodule // rap_server

// >>> verification/rap_server_assertions.sv
// Port checker for the register access packet server
`timescale 1ns/100ps
module rap_server_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Reply stream
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_ready,
  // Register strobes and status
  input wire logic reg_we,
  input wire logic reg_re,
  input wire logic drop_pulse
);
  // ******
  // Reply byte position
  // ******
  logic [15:0] idx_r;
  always_ff @(posedge clk) begin
    if (sys_rst) idx_r <= 16'h0000;
    else if (tx_valid && tx_ready) idx_r <= tx_last ? 16'h0000 : idx_r + 1'b1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_stall; tx_valid && !tx_ready; endsequence
  sequence s_held; tx_valid && $stable(tx_data) && $stable(tx_last); endsequence
  sequence s_rd; reg_re ##1 !reg_re; endsequence
  property p_tx_hold; s_stall |=> s_held; endproperty
  property p_rd_gap; reg_re |-> s_rd; endproperty
  property p_wr_gap; reg_we |=> !reg_we; endproperty
  property p_drop_one; drop_pulse |=> !drop_pulse; endproperty
  property p_zero; tx_valid && idx_r == 16'h0002 |-> tx_data == 8'h00;
  endproperty
  property p_ver; tx_valid && idx_r == 16'h0003 |-> tx_data == 8'h02;
  endproperty
  property p_op; tx_valid && idx_r == 16'h0006 |->
    tx_data[7:5] == 3'b100 || tx_data[7:5] == 3'b010; endproperty
  property p_len; tx_valid && idx_r == 16'h0001 |-> tx_data <= 8'h10;
  endproperty
  property p_last; tx_valid && tx_last |->
    idx_r == 16'h0006 || (idx_r >= 16'h0009 && idx_r[0]); endproperty
  property p_quiet; $fell(sys_rst) |-> !tx_valid && !reg_we && !reg_re;
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("reply byte changed while stalled");
  a_rd_gap: assert property (p_rd_gap)
    else $error("read strobe longer than one cycle");
  a_wr_gap: assert property (p_wr_gap)
    else $error("write strobe longer than one cycle");
  a_drop_one: assert property (p_drop_one)
    else $error("drop pulse longer than one cycle");
  a_zero: assert property (p_zero)
    else $error("reserved reply byte not zero");
  a_ver: assert property (p_ver)
    else $error("reply version not 02");
  a_op: assert property (p_op)
    else $error("reply code not in 80-9f or 40-5f");
  a_len: assert property (p_len)
    else $error("reply length above range");
  a_last: assert property (p_last)
    else $error("reply ends off a word boundary");
  a_quiet: assert property (p_quiet)
    else $error("activity right after reset");
endmodule // rap_server_assertions
bind rap_server rap_server_assertions u_chk (
  .clk(clk), .sys_rst(sys_rst), .tx_valid(tx_valid), .tx_data(tx_data),
  .tx_last(tx_last), .tx_ready(tx_ready), .reg_we(reg_we),
  .reg_re(reg_re), .drop_pulse(drop_pulse));

// >>> verification/rap_client.sv
// Remote client model: sends requests, collects replies
`timescale 1ns/100ps
module rap_client (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Requests to the server
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_first,
  output logic rx_last,
  output logic rx_is_tcp,
  output logic [15:0] rx_dst_port,
  input wire logic rx_ready,
  // Replies from the server
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready
);
  logic slow = 1'b0;
  logic hung = 1'b0;
  logic [8:0] got_q [$];
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_first = 1'b0;
    rx_last = 1'b0;
    rx_is_tcp = 1'b0;
    rx_dst_port = 16'h0000;
    tx_ready = 1'b0;
  end
  // ******
  // Sender
  // ******
  // bytes as built, no checksum or node address
  task automatic send(input logic [7:0] q [$], input logic [15:0] port,
    input logic tcp);
    int n;
    for (int i = 0; i < q.size(); i++) begin
      @(negedge clk);
      rx_valid = 1'b1;
      rx_data = q[i];
      rx_first = (i == 0);
      rx_last = (i == q.size() - 1);
      rx_dst_port = port;
      rx_is_tcp = tcp;
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (!rx_ready && n < 50000);
      if (n >= 50000) hung = 1'b1;
    end
    @(negedge clk);
    rx_valid = 1'b0;
    rx_first = 1'b0;
    rx_last = 1'b0;
    // Idle data flips so a stale byte never looks valid
    rx_data = ~rx_data;
  endtask
  // Random ready while slow, so replies stall mid-packet
  always @(negedge clk) tx_ready <= slow ? ($urandom % 2 == 0) : 1'b1;
  // no retries are sent, so no duplicate reply can arise
  always @(posedge clk)
    if (!sys_rst && tx_valid && tx_ready) got_q.push_back({tx_last, tx_data});
endmodule // rap_client

// >>> verification/register_access_packet_server_tb_top.sv
// Self-checking bench for the register access packet server
`timescale 1ns/100ps
`include "rap_defs.svh"
module register_access_packet_server_tb_top;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic rx_valid, rx_first, rx_last, rx_is_tcp, rx_ready;
  logic tx_valid, tx_last, tx_ready, reg_we, reg_re, drop_pulse;
  logic [7:0] rx_data, tx_data, op;
  logic [15:0] rx_dst_port, reg_addr, reg_wdata, p, base;
  logic [15:0] reg_rdata = 16'h0000;
  logic [15:0] tag = 16'h0000;
  logic [15:0] mdl [int];
  logic [15:0] regs [int];
  logic [8:0] exp_q [$];
  int miscompares = 0;
  int check_count = 0;
  int drops = 0;
  int drops_exp = 0;
  int dummy;
  int cn [5] = '{512, 513, 2048, 2049, 0};
  logic [7:0] bad [3] = '{8'h00, 8'h05, 8'h1f};
  always #25 clk = ~clk;
  rap_server DUT (.clk(clk), .sys_rst(sys_rst), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_first(rx_first), .rx_last(rx_last),
    .rx_is_tcp(rx_is_tcp), .rx_dst_port(rx_dst_port), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .tx_ready(tx_ready), .reg_we(reg_we), .reg_re(reg_re),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .drop_pulse(drop_pulse));
  rap_client cli (.clk(clk), .sys_rst(sys_rst), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_first(rx_first), .rx_last(rx_last),
    .rx_is_tcp(rx_is_tcp), .rx_dst_port(rx_dst_port), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .tx_ready(tx_ready));
  // ******
  // Register space, unwritten words read as inverted address
  // ******
  always @(negedge clk) begin
    if (reg_we) regs[reg_addr] = reg_wdata;
    if (reg_re) reg_rdata <= regs.exists(reg_addr) ? regs[reg_addr] : ~reg_addr;
    if (drop_pulse) drops++;
  end
  function automatic void put(ref logic [7:0] q [$], input logic [15:0] w,
    input logic be);
    q.push_back(be ? w[15:8] : w[7:0]);
    q.push_back(be ? w[7:0] : w[15:8]);
  endfunction
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ******
  // Request builder and reply model
  // ******
  task automatic req(input logic [7:0] op, input logic [7:0] ver,
    input logic [15:0] port, input logic tcp, input int cnt);
    logic [7:0] q [$];
    logic [7:0] r [$];
    logic [15:0] w, a;
    logic ok, be, wr, up;
    int len;
    be = op[1];
    wr = op[0];
    len = wr ? 10 + 2 * cnt : 10;
    up = port == `RAP_PORT_MAIN || port == `RAP_PORT_LEGACY;
    ok = up && ver == 8'h02 && op >= 8'h10 && op <= 8'h13 && cnt >= 1
      && cnt <= (tcp ? 2048 : 512) && len <= (tcp ? 4106 : 1034);
    tag++;
    put(q, len[15:0], 1'b0);
    q.push_back(8'h00);
    q.push_back(ver);
    put(q, tag, 1'b0);
    q.push_back(op);
    q.push_back(8'h00);
    put(q, base, be);
    put(q, cnt[15:0], be);
    for (int i = 0; i < cnt && wr; i++) begin
      w = $urandom;
      put(q, w, be);
      a = base + i[15:0];
      if (ok) mdl[a] = w;
    end
    put(r, (ok && !wr) ? 16'(6 + 2 * cnt) : 16'h0005, 1'b0);
    r.push_back(8'h00);
    r.push_back(8'h02);
    put(r, tag, 1'b0);
    r.push_back(op + (ok ? 8'h80 : 8'h40));
    if (ok && !wr) r.push_back(8'h00);
    // read data in the order the code selects
    for (int i = 0; i < cnt && ok && !wr; i++) begin
      a = base + i[15:0];
      put(r, mdl.exists(a) ? mdl[a] : ~a, be);
    end
    if (up) foreach (r[i]) exp_q.push_back({i == r.size() - 1, r[i]});
    else drops_exp++;
    cli.send(q, port, tcp);
  endtask
  task automatic drain();
    int n = 0;
    while (cli.got_q.size() < exp_q.size() && n < 40000) begin
      @(negedge clk);
      n++;
    end
    // Quiet spell so an extra reply would show
    repeat (40) @(negedge clk);
    chk("reply bytes", exp_q.size(), cli.got_q.size());
    foreach (exp_q[i])
      if (i < cli.got_q.size()) chk("reply byte", exp_q[i], cli.got_q[i]);
    chk("drops", drops_exp, drops);
    if (n >= 40000 || cli.hung) begin
      miscompares++;
      stop_test();
    end
    exp_q.delete();
    cli.got_q.delete();
  endtask
  initial begin
    dummy = $urandom(89);
    base = $urandom;
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    // Mixed codes, ports and transports in flight, with stalls
    cli.slow = 1'b1;
    for (int k = 0; k < 8; k++) begin
      p = k[2] ? `RAP_PORT_LEGACY : `RAP_PORT_MAIN;
      req(8'h10 + 8'(k % 4), 8'h02, p, k[0], 1 + $urandom % 8);
    end
    drain();
    // Count limits at their edges, prompt replies
    cli.slow = 1'b0;
    for (int k = 0; k < 5; k++) begin
      op = k[0] ? 8'h13 : 8'h11;
      req(op, 8'h02, `RAP_PORT_MAIN, k > 1, cn[k]);
    end
    req(8'h12, 8'h02, `RAP_PORT_MAIN, 1'b1, 2048);
    req(8'h10, 8'h02, `RAP_PORT_LEGACY, 1'b0, 512);
    drain();
    // Refused codes, wrong version, stray port, then read back
    cli.slow = 1'b1;
    foreach (bad[k]) req(bad[k], 8'h02, `RAP_PORT_MAIN, 1'b1, 2);
    req(8'h11, 8'h03, `RAP_PORT_MAIN, 1'b0, 4);
    req(8'h13, 8'h02, 16'h0050, 1'b0, 4);
    req(8'h10, 8'h02, `RAP_PORT_MAIN, 1'b0, 8);
    drain();
    stop_test();
  end
endmodule // register_access_packet_server_tb_top
